// ==== logic/cpusc_core.sv ====
// CPU status and core control: ALU flags, accumulator overflow and
// saturation flags, loop indicators, priority level and DSP modes.
// Assumes the CPU datapath drives events on clk_i; registers are reached
// over a plain port with read data one cycle after the read strobe.
//
// Operation
// - Status bits 15 and 14 report first and second accumulator overflow.
// - Saturation bits 13 and 12 are sticky; software may clear, never set.
// - Bit 11 ORs overflow bits; bit 10 ORs saturation bits.
// - Clearing bit 10 clears both accumulator saturation bits.
// - Digit carry takes carry from bit 4 (byte) or bit 8 (word).
// - Priority level is top bit plus three status bits; gates interrupts.
// - Low priority bits ignore writes while nesting disable is set.
// - Signed overflow bit set when result sign wrongly changes.
// - Zero bit cleared by non-zero result; a zero result never clears.
// - Carry bit takes carry from result MSB at 8 or 16 bits.
// - Carry and digit carry act as inverted borrows for subtraction (1 means no borrow).
// - ALU is 16 bits, two's complement, byte or word width.
// - Core control bit 12 selects unsigned DSP multiplies.
// - Writing 1 to bit 11 ends the DO loop early; reads 0.
// - Core control bits 10-8 show active DO loop nesting depth.
// - Bits 7 and 6 enable accumulator saturation.
// - Bit 5 enables store saturation and resets to one.
// - Bit 4 selects super saturation when set.
// - Bit 3 top priority bit is read and clear only.
// - Bit 1 selects rounding style; bit 0 selects integer multiply.
// - Overflow bits update on every accumulator operation from guard bits.
`timescale 1ns/1ns
module cpusc_core
  import cpusc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [CPUSC_AW-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire cpusc_alu_req_t alu_req_i,
  output logic [15:0] alu_result_o,
  input wire cpusc_acc_evt_t acc_evt_i,
  input wire logic loop_block_active_i,
  input wire logic single_repeat_active_i,
  input wire logic [2:0] loop_nest_depth_i,
  input wire logic nest_block_disable_i,
  input wire logic pri_load_i,
  input wire logic [3:0] pri_load_val_i,
  output logic early_loop_exit_o,
  output logic [3:0] cpu_priority_o,
  output logic user_irq_disable_o,
  output cpusc_dsp_mode_t dsp_mode_o
);

  ////////////////////////////////////////////////////////////////////////
  // ALU
  logic [16:0] sum;
  logic [4:0] lo_byte;
  logic [8:0] lo_word;
  logic [15:0] res, bx;
  logic cin, arith, carry_bit, dcarry_bit, sign_bit, wrap_bit, res_zero;

  always_comb
  begin
    arith = (alu_req_i.op == CPUSC_OP_ADD) || (alu_req_i.op == CPUSC_OP_SUB);
    // Subtract as a + ~b + cin; carry out then means no borrow
    bx = (alu_req_i.op == CPUSC_OP_SUB) ? ~alu_req_i.b : alu_req_i.b;
    cin = alu_req_i.carry_in;
    sum = {1'b0, alu_req_i.a} + {1'b0, bx} + {16'h0000, cin};
    lo_byte = {1'b0, alu_req_i.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    lo_word = {1'b0, alu_req_i.a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    res = 16'h0000;
    carry_bit = 1'b0;
    case (alu_req_i.op)
      CPUSC_OP_ADD,
      CPUSC_OP_SUB:
        res = sum[15:0];
      CPUSC_OP_AND:
        res = alu_req_i.a & alu_req_i.b;
      CPUSC_OP_OR:
        res = alu_req_i.a | alu_req_i.b;
      CPUSC_OP_XOR:
        res = alu_req_i.a ^ alu_req_i.b;
      CPUSC_OP_SHL:
      begin
        res = {alu_req_i.a[14:0], 1'b0};
        carry_bit = alu_req_i.byte_mode ? alu_req_i.a[7] : alu_req_i.a[15];
      end
      CPUSC_OP_SHR:
      begin
        res = alu_req_i.byte_mode ? {9'h0, alu_req_i.a[7:1]} :
          {1'b0, alu_req_i.a[15:1]};
        carry_bit = alu_req_i.a[0];
      end
      default:
        res = 16'h0000;
    endcase
    if (alu_req_i.byte_mode)
    begin
      res[15:8] = 8'h00;
    end
    if (arith)
    begin
      // Byte carry is the carry into bit 8 of the full sum
      carry_bit = alu_req_i.byte_mode ? lo_word[8] : sum[16];
    end
    dcarry_bit = alu_req_i.byte_mode ? lo_byte[4] : lo_word[8];
    sign_bit = alu_req_i.byte_mode ? res[7] : res[15];
    wrap_bit = alu_req_i.byte_mode ?
      ((alu_req_i.a[7] == bx[7]) && (res[7] != alu_req_i.a[7])) :
      ((alu_req_i.a[15] == bx[15]) && (res[15] != alu_req_i.a[15]));
    wrap_bit = wrap_bit && arith;
    res_zero = (res == 16'h0000);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alu_result_o <= 16'h0000;
    else if (alu_req_i.valid)
      alu_result_o <= res;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flag registers
  logic carry_r, nibble_byte_carry_r, neg_r, signed_wrap_flag_r, zero_r;
  logic first_acc_guard_overflow_r, second_acc_guard_overflow_r;
  logic first_acc_clamped_sticky_r, second_acc_clamped_sticky_r;
  logic [2:0] cpu_priority_low_r;
  logic cpu_priority_top_r, st_wr, cc_wr;
  assign st_wr = reg_wr_i && (reg_addr_i == CPUSC_STATUS_OFS);
  assign cc_wr = reg_wr_i && (reg_addr_i == CPUSC_CORE_OFS);
  // Hardware results take priority over software writes of ALU flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carry_r <= 1'b0;
      nibble_byte_carry_r <= 1'b0;
      neg_r <= 1'b0;
      signed_wrap_flag_r <= 1'b0;
    end
    else if (alu_req_i.valid)
    begin
      carry_r <= carry_bit;
      nibble_byte_carry_r <= arith ? dcarry_bit : nibble_byte_carry_r;
      neg_r <= sign_bit;
      signed_wrap_flag_r <= wrap_bit;
    end
    else if (st_wr)
    begin
      carry_r <= reg_wdata_i[ST_C];
      nibble_byte_carry_r <= reg_wdata_i[ST_DC];
      neg_r <= reg_wdata_i[ST_NEG];
      signed_wrap_flag_r <= reg_wdata_i[ST_OV];
    end
  end

  // Zero flag: non-zero result clears, zero result leaves it alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      zero_r <= 1'b0;
    else if (alu_req_i.valid)
    begin
      if (!res_zero)
        zero_r <= 1'b0;
    end
    else if (st_wr)
      zero_r <= reg_wdata_i[ST_Z];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_acc_guard_overflow_r <= 1'b0;
      second_acc_guard_overflow_r <= 1'b0;
    end
    else if (acc_evt_i.valid)
    begin
      // Guard bits 39..31 not all equal means overflow into the guard
      first_acc_guard_overflow_r <=
        !((&acc_evt_i.first_accumulator[39:31]) ||
          (~|acc_evt_i.first_accumulator[39:31]));
      second_acc_guard_overflow_r <=
        !((&acc_evt_i.second_accumulator[39:31]) ||
          (~|acc_evt_i.second_accumulator[39:31]));
    end
  end

  // Saturation: set wins over a software clear in the same cycle
  logic clr_sat_a, clr_sat_b;
  assign clr_sat_a = st_wr &&
    (!reg_wdata_i[ST_FIRST_ACC_CLAMP_ENABLE] || !reg_wdata_i[ST_SATAB]);
  assign clr_sat_b = st_wr &&
    (!reg_wdata_i[ST_SECOND_ACC_CLAMP_ENABLE] || !reg_wdata_i[ST_SATAB]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_acc_clamped_sticky_r <= 1'b0;
      second_acc_clamped_sticky_r <= 1'b0;
    end
    else
    begin
      if (acc_evt_i.valid && acc_evt_i.first_sat)
        first_acc_clamped_sticky_r <= 1'b1;
      else if (clr_sat_a)
        first_acc_clamped_sticky_r <= 1'b0;
      if (acc_evt_i.valid && acc_evt_i.second_sat)
        second_acc_clamped_sticky_r <= 1'b1;
      else if (clr_sat_b)
        second_acc_clamped_sticky_r <= 1'b0;
    end
  end

  // Priority level; the CPU may load it on exception entry and return
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cpu_priority_low_r <= 3'h0;
    else if (pri_load_i)
      cpu_priority_low_r <= pri_load_val_i[2:0];
    else if (st_wr && !nest_block_disable_i)
      cpu_priority_low_r <= reg_wdata_i[ST_PRI_HI:ST_PRI_LO];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cpu_priority_top_r <= 1'b0;
    else if (pri_load_i)
      cpu_priority_top_r <= pri_load_val_i[3];
    else if (cc_wr && !reg_wdata_i[CC_PTOP])
      cpu_priority_top_r <= 1'b0;
  end

  assign cpu_priority_o = {cpu_priority_top_r, cpu_priority_low_r};
  assign user_irq_disable_o = cpu_priority_top_r ||
    (cpu_priority_low_r == CPUSC_PRI_MAX);

  ////////////////////////////////////////////////////////////////////////
  // Core control modes
  cpusc_dsp_mode_t mode_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_r <= '{store_clamp_enable: STORE_CLAMP_RST,
        default: 1'b0};
    else if (cc_wr)
    begin
      mode_r.mult_unsigned_sel <= reg_wdata_i[CC_US];
      mode_r.first_acc_clamp_enable <= reg_wdata_i[CC_FIRST_ACC_CLAMP_ENABLE];
      mode_r.second_acc_clamp_enable <= reg_wdata_i[CC_SECOND_ACC_CLAMP_ENABLE];
      mode_r.store_clamp_enable <= reg_wdata_i[CC_STORE_CLAMP_ENABLE];
      mode_r.clamp_width_select <= reg_wdata_i[CC_CLAMP_WIDTH_SELECT];
      mode_r.progspace_window_enable <= reg_wdata_i[CC_PSV];
      mode_r.rounding_style <= reg_wdata_i[CC_RND];
      mode_r.mult_integer_sel <= reg_wdata_i[CC_INT];
    end
  end

  assign dsp_mode_o = mode_r;

  // Early exit request is a one-cycle pulse; the bit itself reads 0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      early_loop_exit_o <= 1'b0;
    else
      early_loop_exit_o <= cc_wr && reg_wdata_i[CC_EXIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read
  logic [15:0] status_view, core_view;

  always_comb
  begin
    status_view = 16'h0000;
    status_view[ST_OVA] = first_acc_guard_overflow_r;
    status_view[ST_OVB] = second_acc_guard_overflow_r;
    status_view[ST_FIRST_ACC_CLAMP_ENABLE] = first_acc_clamped_sticky_r;
    status_view[ST_SECOND_ACC_CLAMP_ENABLE] = second_acc_clamped_sticky_r;
    status_view[ST_OVAB] = first_acc_guard_overflow_r ||
      second_acc_guard_overflow_r;
    status_view[ST_SATAB] = first_acc_clamped_sticky_r ||
      second_acc_clamped_sticky_r;
    status_view[ST_LOOP] = loop_block_active_i;
    status_view[ST_DC] = nibble_byte_carry_r;
    status_view[ST_PRI_HI:ST_PRI_LO] = cpu_priority_low_r;
    status_view[ST_REP] = single_repeat_active_i;
    status_view[ST_NEG] = neg_r;
    status_view[ST_OV] = signed_wrap_flag_r;
    status_view[ST_Z] = zero_r;
    status_view[ST_C] = carry_r;
    core_view = 16'h0000;
    core_view[CC_US] = mode_r.mult_unsigned_sel;
    core_view[CC_DL_HI:CC_DL_LO] = loop_nest_depth_i;
    core_view[CC_FIRST_ACC_CLAMP_ENABLE] = mode_r.first_acc_clamp_enable;
    core_view[CC_SECOND_ACC_CLAMP_ENABLE] = mode_r.second_acc_clamp_enable;
    core_view[CC_STORE_CLAMP_ENABLE] = mode_r.store_clamp_enable;
    core_view[CC_CLAMP_WIDTH_SELECT] = mode_r.clamp_width_select;
    core_view[CC_PTOP] = cpu_priority_top_r;
    core_view[CC_PSV] = mode_r.progspace_window_enable;
    core_view[CC_RND] = mode_r.rounding_style;
    core_view[CC_INT] = mode_r.mult_integer_sel;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i && reg_addr_i == CPUSC_STATUS_OFS)
      reg_rdata_o <= status_view;
    else if (reg_rd_i && reg_addr_i == CPUSC_CORE_OFS)
      reg_rdata_o <= core_view;
    else
      reg_rdata_o <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sat_never_set_by_sw;
    @(posedge clk_i) disable iff (rst_i)
    (!first_acc_clamped_sticky_r && !(acc_evt_i.valid && acc_evt_i.first_sat))
      |=> !first_acc_clamped_sticky_r;
  endproperty
  a_sat_never_set_by_sw: assert property (p_sat_never_set_by_sw)
    else $error("first saturation bit set without event");
  property p_sat_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (acc_evt_i.valid && acc_evt_i.second_sat) |=> second_acc_clamped_sticky_r;
  endproperty
  a_sat_sticky: assert property (p_sat_sticky)
    else $error("second saturation event lost");
  property p_combined_clear;
    @(posedge clk_i) disable iff (rst_i)
    (st_wr && !reg_wdata_i[ST_SATAB] && !acc_evt_i.valid) |=>
      !first_acc_clamped_sticky_r && !second_acc_clamped_sticky_r;
  endproperty
  a_combined_clear: assert property (p_combined_clear)
    else $error("combined clear left a saturation bit");
  property p_zero_hold;
    @(posedge clk_i) disable iff (rst_i)
    (alu_req_i.valid && res_zero) |=> zero_r == $past(zero_r);
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("zero result changed zero flag");
  property p_zero_clear;
    @(posedge clk_i) disable iff (rst_i)
    (alu_req_i.valid && !res_zero) |=> !zero_r;
  endproperty
  a_zero_clear: assert property (p_zero_clear)
    else $error("non-zero result left zero flag");
  property p_pri_locked;
    @(posedge clk_i) disable iff (rst_i)
    (st_wr && nest_block_disable_i && !pri_load_i) |=>
      $stable(cpu_priority_low_r);
  endproperty
  a_pri_locked: assert property (p_pri_locked)
    else $error("priority changed while locked");
  property p_pri_load;
    @(posedge clk_i) disable iff (rst_i)
    pri_load_i |=> cpu_priority_o == $past(pri_load_val_i);
  endproperty
  a_pri_load: assert property (p_pri_load)
    else $error("priority level load not taken");
  property p_top_clear_only;
    @(posedge clk_i) disable iff (rst_i)
    (!cpu_priority_top_r && !pri_load_i) |=> !cpu_priority_top_r;
  endproperty
  a_top_clear_only: assert property (p_top_clear_only)
    else $error("top priority bit set by software");
  property p_exit_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (cc_wr && reg_wdata_i[CC_EXIT]) |=> early_loop_exit_o ##1
      (early_loop_exit_o == $past(cc_wr && reg_wdata_i[CC_EXIT]));
  endproperty
  a_exit_pulse: assert property (p_exit_pulse)
    else $error("early exit pulse wrong");
  property p_core_read;
    @(posedge clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == CPUSC_CORE_OFS) |=>
      reg_rdata_o[15:13] == 3'h0 && !reg_rdata_o[CC_EXIT] &&
      reg_rdata_o[CC_DL_HI:CC_DL_LO] == $past(loop_nest_depth_i);
  endproperty
  a_core_read: assert property (p_core_read)
    else $error("core control read wrong");

endmodule : cpusc_core

// ==== inc/cpusc_pkg.sv ====
// Constants and carriers for the CPU status and core control block.
// Assumes one clock and a plain register port beside the CPU datapath.
package cpusc_pkg;
  localparam int unsigned CPUSC_AW = 4;
  localparam logic [3:0] CPUSC_STATUS_OFS = 4'h0;
  localparam logic [3:0] CPUSC_CORE_OFS = 4'h1;
  // Status bit positions
  localparam int unsigned ST_OVA = 15;
  localparam int unsigned ST_OVB = 14;
  localparam int unsigned ST_FIRST_ACC_CLAMP_ENABLE = 13;
  localparam int unsigned ST_SECOND_ACC_CLAMP_ENABLE = 12;
  localparam int unsigned ST_OVAB = 11;
  localparam int unsigned ST_SATAB = 10;
  localparam int unsigned ST_LOOP = 9;
  localparam int unsigned ST_DC = 8;
  localparam int unsigned ST_PRI_HI = 7;
  localparam int unsigned ST_PRI_LO = 5;
  localparam int unsigned ST_REP = 4;
  localparam int unsigned ST_NEG = 3;
  localparam int unsigned ST_OV = 2;
  localparam int unsigned ST_Z = 1;
  localparam int unsigned ST_C = 0;
  // Core control bit positions
  localparam int unsigned CC_US = 12;
  localparam int unsigned CC_EXIT = 11;
  localparam int unsigned CC_DL_HI = 10;
  localparam int unsigned CC_DL_LO = 8;
  localparam int unsigned CC_FIRST_ACC_CLAMP_ENABLE = 7;
  localparam int unsigned CC_SECOND_ACC_CLAMP_ENABLE = 6;
  localparam int unsigned CC_STORE_CLAMP_ENABLE = 5;
  localparam int unsigned CC_CLAMP_WIDTH_SELECT = 4;
  localparam int unsigned CC_PTOP = 3;
  localparam int unsigned CC_PSV = 2;
  localparam int unsigned CC_RND = 1;
  localparam int unsigned CC_INT = 0;
  localparam logic [2:0] CPUSC_PRI_MAX = 3'h7;
  localparam logic STORE_CLAMP_RST = 1'b1;

  typedef enum logic [2:0] {
    CPUSC_OP_ADD,
    CPUSC_OP_SUB,
    CPUSC_OP_AND,
    CPUSC_OP_OR,
    CPUSC_OP_XOR,
    CPUSC_OP_SHL,
    CPUSC_OP_SHR
  } cpusc_op_t;

  typedef struct packed {
    logic valid;
    cpusc_op_t op;
    logic byte_mode;
    logic carry_in;
    logic [15:0] a;
    logic [15:0] b;
  } cpusc_alu_req_t;

  typedef struct packed {
    logic valid;
    logic [39:0] first_accumulator;
    logic [39:0] second_accumulator;
    logic first_sat;
    logic second_sat;
  } cpusc_acc_evt_t;

  typedef struct packed {
    logic mult_unsigned_sel;
    logic first_acc_clamp_enable;
    logic second_acc_clamp_enable;
    logic store_clamp_enable;
    logic clamp_width_select;
    logic progspace_window_enable;
    logic rounding_style;
    logic mult_integer_sel;
  } cpusc_dsp_mode_t;
endpackage : cpusc_pkg

// ==== bench/cpusc_dp_model.sv ====
// Model of the CPU execution datapath that feeds ALU and accumulator events.
// Assumes the bench calls its tasks; each event is a one-cycle pulse.
`timescale 1ns/1ns
module cpusc_dp_model
  import cpusc_pkg::*;
(
  input wire logic clk_i,
  output cpusc_alu_req_t alu_req_o,
  output cpusc_acc_evt_t acc_evt_o
);
  initial
  begin
    alu_req_o = '0;
    acc_evt_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issue one ALU operation; operands are scrambled once the pulse is over
  task automatic alu_op(input cpusc_op_t op, input logic bm, input logic ci,
                        input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_i);
    alu_req_o <= '{1'b1, op, bm, ci, a, b};
    @(posedge clk_i);
    alu_req_o <= '{1'b0, op, ~bm, ~ci, ~a, ~b};
  endtask : alu_op

  ////////////////////////////////////////////////////////////////////////////
  // Report one accumulator operation with its saturation indications
  task automatic acc_op(input logic [39:0] fa, input logic [39:0] sa,
                        input logic fs, input logic ss);
    @(posedge clk_i);
    acc_evt_o <= '{1'b1, fa, sa, fs, ss};
    @(posedge clk_i);
    acc_evt_o <= '{1'b0, ~fa, ~sa, ~fs, ~ss};
  endtask : acc_op
endmodule : cpusc_dp_model

// ==== bench/cpu_status_core_control_bench.sv ====
// Self-checking bench for the CPU status and core control block.
// Assumes the datapath model in cpusc_dp_model and a 50 MHz clock.
`timescale 1ns/1ns
module cpu_status_core_control_bench;
  import cpusc_pkg::*;
  logic clk;
  logic rst;
  logic [CPUSC_AW-1:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  cpusc_alu_req_t alu_req;
  logic [15:0] alu_result;
  cpusc_acc_evt_t acc_evt;
  logic loop_act;
  logic rep_act;
  logic [2:0] depth;
  logic nest_dis;
  logic pri_load;
  logic [3:0] pri_val;
  logic early_exit;
  logic [3:0] cpu_pri;
  logic irq_dis;
  cpusc_dsp_mode_t dsp_mode;
  int miscompares = 0;
  int comparisons = 0;

  cpusc_core i_cpusc_core (.clk_i(clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .alu_req_i(alu_req), .alu_result_o(alu_result),
    .acc_evt_i(acc_evt), .loop_block_active_i(loop_act),
    .single_repeat_active_i(rep_act), .loop_nest_depth_i(depth),
    .nest_block_disable_i(nest_dis), .pri_load_i(pri_load),
    .pri_load_val_i(pri_val), .early_loop_exit_o(early_exit),
    .cpu_priority_o(cpu_pri), .user_irq_disable_o(irq_dis),
    .dsp_mode_o(dsp_mode));

  cpusc_dp_model i_cpusc_dp_model (.clk_i(clk), .alu_req_o(alu_req),
    .acc_evt_o(acc_evt));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register port tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic end_of_test();
    $display("Mismatches %0d of %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] m,
                    input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask : rd

  task automatic alu_chk(input cpusc_op_t op, input logic bm, input logic ci,
    input logic [15:0] a, input logic [15:0] b, input logic [15:0] res,
    input logic [15:0] m, input logic [15:0] fl);
    i_cpusc_dp_model.alu_op(op, bm, ci, a, b);
    #1;
    chk(alu_result, res);
    rd(CPUSC_STATUS_OFS, m, fl);
  endtask : alu_chk

  task automatic pri_chk(input logic [3:0] p, input logic d);
    chk({12'h000, cpu_pri}, {12'h000, p});
    chk({15'h0000, irq_dis}, {15'h0000, d});
  endtask : pri_chk

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    loop_act = 1'b0;
    rep_act = 1'b0;
    depth = 3'h0;
    nest_dis = 1'b0;
    pri_load = 1'b0;
    pri_val = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(CPUSC_STATUS_OFS, 16'hffff, 16'h0000);
    rd(CPUSC_CORE_OFS, 16'hffff, 16'h0020);
    chk({8'h00, dsp_mode}, 16'h0010);
    pri_chk(4'h0, 1'b0);
    // Core control: every writable mode, exit pulse, read-only depth
    rd(4'h2, 16'hffff, 16'h0000);
    @(posedge clk);
    depth <= 3'h5;
    wr(CPUSC_CORE_OFS, 16'hffff);
    chk({15'h0000, early_exit}, 16'h0001);
    @(posedge clk);
    #1;
    chk({15'h0000, early_exit}, 16'h0000);
    chk({8'h00, dsp_mode}, 16'h00ff);
    rd(CPUSC_CORE_OFS, 16'hffff, 16'h15f7);
    wr(CPUSC_CORE_OFS, 16'h0000);
    wr(4'h2, 16'hffff);
    chk({8'h00, dsp_mode}, 16'h0000);
    rd(CPUSC_CORE_OFS, 16'hffff, 16'h0500);
    @(posedge clk);
    loop_act <= 1'b1;
    rep_act <= 1'b1;
    rd(CPUSC_STATUS_OFS, 16'h0210, 16'h0210);
    @(posedge clk);
    loop_act <= 1'b0;
    rep_act <= 1'b0;
    // Priority level from software, nesting lock and CPU load
    wr(CPUSC_STATUS_OFS, 16'h00e0);
    pri_chk(4'h7, 1'b1);
    @(posedge clk);
    nest_dis <= 1'b1;
    wr(CPUSC_STATUS_OFS, 16'h0040);
    pri_chk(4'h7, 1'b1);
    @(posedge clk);
    nest_dis <= 1'b0;
    wr(CPUSC_STATUS_OFS, 16'h0040);
    pri_chk(4'h2, 1'b0);
    @(posedge clk);
    pri_load <= 1'b1;
    pri_val <= 4'h8;
    @(posedge clk);
    pri_load <= 1'b0;
    pri_val <= 4'h3;
    #1;
    pri_chk(4'h8, 1'b1);
    wr(CPUSC_CORE_OFS, 16'h0008);
    pri_chk(4'h8, 1'b1);
    wr(CPUSC_CORE_OFS, 16'h0000);
    pri_chk(4'h0, 1'b0);
    // ALU flags: a set zero flag survives a zero result
    wr(CPUSC_STATUS_OFS, 16'h0002);
    alu_chk(CPUSC_OP_ADD, 0, 0, 16'h0000, 16'h0000, 16'h0000, 16'h010f,
            16'h0002);
    alu_chk(CPUSC_OP_ADD, 0, 0, 16'h7fff, 16'h0001, 16'h8000, 16'h010f,
            16'h010c);
    alu_chk(CPUSC_OP_SUB, 0, 1, 16'h0000, 16'h0001, 16'hffff, 16'h010f,
            16'h0008);
    alu_chk(CPUSC_OP_ADD, 1, 0, 16'h000f, 16'h0001, 16'h0010, 16'h010f,
            16'h0100);
    alu_chk(CPUSC_OP_ADD, 1, 0, 16'h00ff, 16'h0001, 16'h0000, 16'h010f,
            16'h0101);
    alu_chk(CPUSC_OP_SUB, 1, 1, 16'h0080, 16'h0001, 16'h007f, 16'h010f,
            16'h0005);
    alu_chk(CPUSC_OP_AND, 0, 0, 16'hf0f0, 16'hff00, 16'hf000, 16'h000f,
            16'h0008);
    alu_chk(CPUSC_OP_OR, 0, 0, 16'h0001, 16'h8000, 16'h8001, 16'h000f,
            16'h0008);
    alu_chk(CPUSC_OP_XOR, 0, 0, 16'h8001, 16'h8001, 16'h0000, 16'h000f,
            16'h0000);
    alu_chk(CPUSC_OP_SHL, 0, 0, 16'h8001, 16'h0001, 16'h0002, 16'h000f,
            16'h0001);
    alu_chk(CPUSC_OP_SHR, 0, 0, 16'h0003, 16'h0001, 16'h0001, 16'h000f,
            16'h0001);
    alu_chk(CPUSC_OP_SHR, 1, 0, 16'h0102, 16'h0001, 16'h0001, 16'h000f,
            16'h0000);
    // Accumulator overflow and sticky saturation
    i_cpusc_dp_model.acc_op(40'h00_8000_0000, 40'h0, 1'b1, 1'b0);
    rd(CPUSC_STATUS_OFS, 16'hfc00, 16'hac00);
    i_cpusc_dp_model.acc_op(40'hff_ffff_ffff, 40'hff_0000_0000, 1'b0,
                            1'b1);
    rd(CPUSC_STATUS_OFS, 16'hfc00, 16'h7c00);
    wr(CPUSC_STATUS_OFS, 16'hfe10);
    rd(CPUSC_STATUS_OFS, 16'hfe10, 16'h7c00);
    wr(CPUSC_STATUS_OFS, 16'h2400);
    rd(CPUSC_STATUS_OFS, 16'hfc00, 16'h6c00);
    wr(CPUSC_STATUS_OFS, 16'h3000);
    rd(CPUSC_STATUS_OFS, 16'hfc00, 16'h4800);
    i_cpusc_dp_model.acc_op(40'h0, 40'h0, 1'b0, 1'b0);
    wr(CPUSC_STATUS_OFS, 16'hfe10);
    rd(CPUSC_STATUS_OFS, 16'hfe10, 16'h0000);
    end_of_test();
  end
endmodule : cpu_status_core_control_bench
